// >>> hdl/special_reg_page_stack.v
/*
 * page selection and page stack for the special register window of an
 * 8051-class core, with an apb view of the page registers.
 * assumes core strobes and apb are synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "page_stack_defs.vh"

// Behaviour
// - direct accesses to 0x80..0xff go to special registers, not data memory.
// - addresses ending 0x0 or 0x8 allow bit access; others byte only.
// - page select is eight bits wide, 256 pages.
// - only pages 0x0 and 0xf are populated; shared registers on both.
// - five byte-wide stack entries; page select is the top.
// - stack view returns the entry picked by stack index.
// - reading page select returns the top entry.
// - interrupt entry shifts the stack down by one.
// - last entry step loads the interrupting source's page.
// - interrupt return restores page from entry one, shifts up.
// - automatic paging enabled after reset until firmware clears it.
// - with paging disabled, entry and return leave the stack alone.
// - push only on interrupt service, pop only on interrupt return.
// - software page writes change only the top entry.
// - page select at 0xa7, all pages, read/write, resets to zero.
// - page control at 0xcf: enable bit 0 resets 1, index bits 6:4.
// - stack view at 0xd3 page 0xf, read-only, resets to zero.
module special_reg_page_stack (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // core direct access
    input wire dir_valid,
    input wire dir_write,
    input wire dir_bit,
    input wire [7:0] dir_addr,
    input wire [7:0] dir_wdata,
    // interrupt sequencer
    input wire int_enter,
    input wire [7:0] int_page,
    input wire interrupt_return,
    // core-facing outputs
    output reg [7:0] dir_rdata,
    output reg sr_sel,
    output reg bit_ok,
    output reg [7:0] cur_page,
    output reg auto_page_enable
);
    reg [7:0] ctl_r;
    reg [7:0] ctl_nxt;
    reg [7:0] view_r;
    reg sel_bad_r;
    reg [31:0] rd_nxt;
    reg err_nxt;
    reg [7:0] dr_nxt;
    wire [7:0] top;
    wire [7:0] sel_data;
    wire sel_valid;
    wire apb_acc;
    wire apb_wr;
    wire d_in_sr;
    wire d_wr;
    wire push;
    wire pop;
    wire top_wr;
    wire [7:0] top_data;

    // ***************************************************
    // decode helpers
    // ***************************************************
    function in_sr_window;
        input [7:0] a;
        begin
            in_sr_window = (a >= `PS_SR_LOW) && (a <= `PS_SR_HIGH);
        end
    endfunction

    function bit_addressable;
        input [7:0] a;
        begin
            bit_addressable = (a[2:0] == 3'h0);
        end
    endfunction

    assign apb_acc = psel && penable && !pready;
    assign apb_wr = apb_acc && pwrite;
    assign d_in_sr = dir_valid && in_sr_window(dir_addr);
    // core bit writes come in as read-modify-write bytes, so a full byte is taken
    assign d_wr = d_in_sr && dir_write;

    // ***************************************************
    // stack control
    // ***************************************************
    assign push = int_enter && ctl_r[`PS_CTL_EN_BIT];
    assign pop = interrupt_return && !int_enter && ctl_r[`PS_CTL_EN_BIT];
    assign top_wr = (d_wr && dir_addr == `PS_IDX_PAGE_SELECT) ||
        (apb_wr && paddr == `PS_OFS_PAGE_SELECT);
    assign top_data = (d_wr && dir_addr == `PS_IDX_PAGE_SELECT) ? dir_wdata : pwdata[7:0];

    page_stack_core #(
        .DEPTH(`PS_DEPTH)
    ) u_stack (
        .pclk(pclk),
        .presetn(presetn),
        .push(push),
        .pop(pop),
        .push_page(int_page),
        .top_wr(top_wr),
        .top_data(top_data),
        .sel(ctl_r[`PS_CTL_IDX_MSB:`PS_CTL_IDX_LSB]),
        .top(top),
        .sel_data(sel_data),
        .sel_valid(sel_valid)
    );

    // ***************************************************
    // page control register
    // ***************************************************
    always @* begin
        ctl_nxt = ctl_r;
        // reserved bits forced to zero
        if (d_wr && dir_addr == `PS_IDX_PAGE_CONTROL) begin
            ctl_nxt = dir_wdata & 8'h71;
        end else if (apb_wr && paddr == `PS_OFS_PAGE_CONTROL) begin
            ctl_nxt = pwdata[7:0] & 8'h71;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= `PS_CTL_RESET;
            view_r <= `PS_VIEW_RESET;
            sel_bad_r <= 1'b0;
            cur_page <= `PS_PAGE_RESET;
            auto_page_enable <= 1'b1;
        end else begin
            ctl_r <= ctl_nxt;
            view_r <= sel_valid ? sel_data : 8'h00;
            sel_bad_r <= !sel_valid;
            cur_page <= top;
            auto_page_enable <= ctl_nxt[`PS_CTL_EN_BIT];
        end
    end

    // ***************************************************
    // core direct read path
    // ***************************************************
    // the view register exists on page 0xf only; unmapped addresses read zero
    always @* begin
        dr_nxt = 8'h00;
        if (d_in_sr && !dir_write) begin
            case (dir_addr)
                `PS_IDX_PAGE_SELECT: dr_nxt = top;
                `PS_IDX_PAGE_CONTROL: dr_nxt = ctl_r;
                `PS_IDX_STACK_VIEW: begin
                    if (top == `PS_PAGE_F) begin
                        dr_nxt = sel_valid ? sel_data : 8'h00;
                    end
                end
                default: dr_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_rdata <= 8'h00;
            sr_sel <= 1'b0;
            bit_ok <= 1'b0;
        end else begin
            dir_rdata <= dr_nxt;
            sr_sel <= d_in_sr;
            bit_ok <= d_in_sr && (!dir_bit || bit_addressable(dir_addr));
        end
    end

    // ***************************************************
    // apb slave
    // ***************************************************
    // one wait state keeps the answer a flip-flop output
    always @* begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            `PS_OFS_PAGE_SELECT: rd_nxt = {24'h000000, top};
            `PS_OFS_PAGE_CONTROL: rd_nxt = {24'h000000, ctl_r};
            `PS_OFS_STACK_VIEW: begin
                rd_nxt = {24'h000000, view_r};
                err_nxt = pwrite;
            end
            `PS_OFS_STATUS: rd_nxt = {30'h0, sel_bad_r, ctl_r[`PS_CTL_EN_BIT]};
            default: err_nxt = 1'b1;
        endcase
        if (pwrite) begin
            rd_nxt = 32'h0000_0000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_acc) begin
            pready <= 1'b1;
            prdata <= rd_nxt;
            pslverr <= err_nxt;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end
endmodule // special_reg_page_stack
`default_nettype wire

// >>> common/page_stack_defs.vh
/*
 * offsets, field positions, reset values and page codes of the special
 * register page stack block.
 * assumes inclusion by bare name from design and bench files.
 */
`ifndef PAGE_STACK_DEFS_VH
`define PAGE_STACK_DEFS_VH

// ***************************************************
// register addresses and apb byte offsets (register address times four)
// ***************************************************
`define PS_IDX_PAGE_SELECT 8'ha7
`define PS_IDX_PAGE_CONTROL 8'hcf
`define PS_IDX_STACK_VIEW 8'hd3
`define PS_OFS_PAGE_SELECT 12'h29c
`define PS_OFS_PAGE_CONTROL 12'h33c
`define PS_OFS_STACK_VIEW 12'h34c
`define PS_OFS_STATUS 12'h400

// ***************************************************
// special register window and pages
// ***************************************************
`define PS_SR_LOW 8'h80
`define PS_SR_HIGH 8'hff
`define PS_PAGE_0 8'h00
`define PS_PAGE_F 8'h0f

// ***************************************************
// page control fields and reset values
// ***************************************************
`define PS_CTL_EN_BIT 0
`define PS_CTL_IDX_LSB 4
`define PS_CTL_IDX_MSB 6
`define PS_CTL_RESET 8'h01
`define PS_PAGE_RESET 8'h00
`define PS_VIEW_RESET 8'h00
`define PS_DEPTH 5

`endif

// >>> hdl/page_stack_core.v
/*
 * five-entry page stack: top entry is the page select value, entries
 * one to four hold saved pages; push, pop and top write.
 * assumes the caller never asserts push and pop in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "page_stack_defs.vh"

module page_stack_core #(
    parameter DEPTH = `PS_DEPTH
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // stack operations
    input wire push,
    input wire pop,
    input wire [7:0] push_page,
    input wire top_wr,
    input wire [7:0] top_data,
    // view
    input wire [2:0] sel,
    output wire [7:0] top,
    output reg [7:0] sel_data,
    output reg sel_valid
);
    reg [7:0] ent_r [0:DEPTH-1];
    genvar g;

    // ***************************************************
    // top entry
    // ***************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ent_r[0] <= `PS_PAGE_RESET;
        end else if (push) begin
            ent_r[0] <= push_page;
        end else if (pop) begin
            ent_r[0] <= ent_r[1];
        end else if (top_wr) begin
            ent_r[0] <= top_data;
        end
    end

    // ***************************************************
    // deeper entries
    // ***************************************************
    generate
        for (g = 1; g < DEPTH; g = g + 1) begin : lvl
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ent_r[g] <= `PS_PAGE_RESET;
                end else if (push) begin
                    // old bottom falls off on the fifth nesting
                    ent_r[g] <= ent_r[g-1];
                end else if (pop && g < DEPTH - 1) begin
                    // index clamped so the bottom level never names a missing entry
                    ent_r[g] <= ent_r[(g < DEPTH - 1) ? g + 1 : g];
                end
                // bottom keeps its value on pop
            end
        end
    endgenerate

    assign top = ent_r[0];

    // ***************************************************
    // view mux
    // ***************************************************
    always @* begin
        sel_valid = (sel < DEPTH);
        sel_data = 8'h00;
        if (sel < DEPTH) begin
            sel_data = ent_r[sel];
        end
    end
endmodule // page_stack_core
`default_nettype wire

// >>> tb/page_stack_checker.sv
/* port assertions of the page stack block.
   assumes a bind into special_reg_page_stack. */
`timescale 1ns/1ps
`default_nettype none
module page_stack_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // core side
    input wire logic dir_valid,
    input wire logic dir_bit,
    input wire logic [7:0] dir_addr,
    input wire logic int_enter,
    input wire logic [7:0] int_page,
    input wire logic interrupt_return,
    input wire logic sr_sel,
    input wire logic bit_ok,
    input wire logic [7:0] cur_page,
    input wire logic auto_page_enable
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// ****************
// assertions
// ****************
apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
sr_window_a: assert property (dir_valid |=> sr_sel == $past(dir_addr[7]))
    else $error("window decode wrong");
bit_ok_a: assert property (dir_valid && dir_bit && dir_addr[7] |=>
    bit_ok == ($past(dir_addr[2:0]) == 3'h0))
    else $error("bit access check wrong");
enable_reset_a: assert property ($rose(presetn) |-> auto_page_enable)
    else $error("paging off after reset");
push_page_a: assert property (int_enter && auto_page_enable |=>
    ##1 cur_page == $past(int_page, 2))
    else $error("source page not loaded");
off_hold_a: assert property (int_enter && !auto_page_enable && !dir_valid
    && !(psel && penable) |=> ##1 $stable(cur_page))
    else $error("page moved while disabled");
idle_hold_a: assert property (!int_enter && !interrupt_return && !dir_valid
    && !(psel && penable) |=> ##1 $stable(cur_page))
    else $error("page moved while idle");
endmodule // page_stack_checker

bind special_reg_page_stack page_stack_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .dir_valid(dir_valid),
    .dir_bit(dir_bit), .dir_addr(dir_addr), .int_enter(int_enter),
    .int_page(int_page), .interrupt_return(interrupt_return),
    .sr_sel(sr_sel), .bit_ok(bit_ok), .cur_page(cur_page),
    .auto_page_enable(auto_page_enable));
`default_nettype wire

// >>> tb/core_model.sv
/* core and interrupt sequencer model: direct accesses, entry, return.
   assumes one clock shared with the block. */
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // clock
    input wire logic pclk,
    // direct access
    output logic dir_valid,
    output logic dir_write,
    output logic dir_bit,
    output logic [7:0] dir_addr,
    output logic [7:0] dir_wdata,
    input wire logic [7:0] dir_rdata,
    // interrupts
    output logic int_enter,
    output logic [7:0] int_page,
    output logic interrupt_return
);
// ****************
// strobes
// ****************
initial begin
    dir_valid = 1'b0;
    dir_write = 1'b0;
    dir_bit = 1'b0;
    dir_addr = 8'h00;
    dir_wdata = 8'h00;
    int_enter = 1'b0;
    int_page = 8'h00;
    interrupt_return = 1'b0;
end
// any address is accepted, including ones outside the special register window
task automatic acc(input logic w, input logic b, input logic [7:0] a,
                   input logic [7:0] d, output logic [7:0] rd);
    @(posedge pclk);
    dir_valid <= 1'b1;
    dir_write <= w;
    dir_bit <= b;
    dir_addr <= a;
    dir_wdata <= d;
    @(posedge pclk);
    dir_valid <= 1'b0;
    dir_addr <= ~a;
    dir_wdata <= ~d;
    @(posedge pclk);
    rd = dir_rdata;
endtask
task automatic enter(input logic [7:0] p);
    @(posedge pclk);
    int_enter <= 1'b1;
    int_page <= p;
    @(posedge pclk);
    int_enter <= 1'b0;
    int_page <= ~p;
endtask
task automatic ret;
    @(posedge pclk);
    interrupt_return <= 1'b1;
    @(posedge pclk);
    interrupt_return <= 1'b0;
endtask
endmodule // core_model
`default_nettype wire

// >>> tb/special_reg_page_stack_test.sv
/* self-checking bench of the page stack block.
   assumes core_model and the checker bind are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "page_stack_defs.vh"
module special_reg_page_stack_test;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
logic [11:0] paddr;
logic [31:0] pwdata, prdata;
logic dir_valid, dir_write, dir_bit, int_enter, interrupt_return;
logic [7:0] dir_addr, dir_wdata, int_page, dir_rdata, cur_page, rd;
logic sr_sel, bit_ok, auto_page_enable, e;
int mismatches = 0;
int samples_checked = 0;
special_reg_page_stack u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dir_valid(dir_valid), .dir_write(dir_write), .dir_bit(dir_bit),
    .dir_addr(dir_addr), .dir_wdata(dir_wdata), .int_enter(int_enter),
    .int_page(int_page), .interrupt_return(interrupt_return),
    .dir_rdata(dir_rdata), .sr_sel(sr_sel), .bit_ok(bit_ok),
    .cur_page(cur_page), .auto_page_enable(auto_page_enable));
core_model u_core (.pclk(pclk), .dir_valid(dir_valid), .dir_write(dir_write),
    .dir_bit(dir_bit), .dir_addr(dir_addr), .dir_wdata(dir_wdata),
    .dir_rdata(dir_rdata), .int_enter(int_enter), .int_page(int_page),
    .interrupt_return(interrupt_return));
// ****************
// helpers
// ****************
task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x) begin
        $display("[ERR] %s expected %h seen %h", n, x, g);
        mismatches++;
    end
endtask
task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
        mismatches++;
        conclude();
    end
    rd = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~pwdata;
endtask
task automatic rd_chk(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), x, rd);
endtask
task conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
// ****************
// scenarios
// ****************
task t_reset;
    rd_chk(`PS_OFS_PAGE_SELECT, `PS_PAGE_RESET);
    rd_chk(`PS_OFS_PAGE_CONTROL, `PS_CTL_RESET);
    rd_chk(`PS_OFS_STACK_VIEW, `PS_VIEW_RESET);
    chk("enable", 8'h01, {7'h00, auto_page_enable});
endtask
task t_apb;
    apb(1'b1, `PS_OFS_PAGE_SELECT, 8'hff);
    rd_chk(`PS_OFS_PAGE_SELECT, 8'hff);
    apb(1'b1, `PS_OFS_STACK_VIEW, 8'h55);
    chk("view write err", 8'h01, {7'h00, e});
    rd_chk(`PS_OFS_STACK_VIEW, 8'hff);
    apb(1'b0, 12'h010, 8'h00);
    chk("unmapped err", 8'h01, {7'h00, e});
endtask
// six pushes overflow the five entries, then five pops drain them
task t_nest;
    apb(1'b1, `PS_OFS_PAGE_SELECT, `PS_PAGE_F);
    for (int i = 1; i <= 6; i++) u_core.enter(8'(i));
    for (int i = 0; i < 8; i++) begin
        apb(1'b1, `PS_OFS_PAGE_CONTROL, {1'b0, 3'(i), 4'h1});
        rd_chk(`PS_OFS_STACK_VIEW, 8'(i < 5 ? 6 - i : 0));
    end
    rd_chk(`PS_OFS_PAGE_SELECT, 8'h06);
    for (int i = 0; i < 5; i++) begin
        u_core.ret();
        rd_chk(`PS_OFS_PAGE_SELECT, 8'(i < 4 ? 5 - i : 2));
    end
endtask
task t_soft;
    u_core.enter(`PS_PAGE_F);
    u_core.acc(1'b1, 1'b0, `PS_IDX_PAGE_SELECT, 8'h33, rd);
    apb(1'b1, `PS_OFS_PAGE_CONTROL, 8'h11);
    rd_chk(`PS_OFS_STACK_VIEW, 8'h02);
    u_core.acc(1'b0, 1'b1, `PS_IDX_PAGE_SELECT, 8'h00, rd);
    chk("dir page", 8'h33, rd);
    u_core.acc(1'b0, 1'b0, 8'h10, 8'h00, rd);
    u_core.ret();
    rd_chk(`PS_OFS_PAGE_SELECT, 8'h02);
endtask
task t_off;
    apb(1'b1, `PS_OFS_PAGE_CONTROL, 8'h00);
    chk("enable off", 8'h00, {7'h00, auto_page_enable});
    u_core.enter(8'h44);
    rd_chk(`PS_OFS_PAGE_SELECT, 8'h02);
    u_core.ret();
    rd_chk(`PS_OFS_PAGE_SELECT, 8'h02);
endtask
// ****************
// run
// ****************
initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
end
initial begin
    #50000;
    mismatches++;
    conclude();
end
initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_apb();
    t_nest();
    t_soft();
    t_off();
    conclude();
end
endmodule // special_reg_page_stack_test
`default_nettype wire
